// *** pfs_supervisor.sv ***
`timescale 1ns/100ps

module pfs_filter #(
  parameter logic [16:0] Cycles = 17'h00001
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Raw and filtered level
  input wire logic rawIn,
  output logic filtOut
);
  logic [16:0] count_q;
  logic state_q;

  // Counter restarts whenever the raw level agrees with the filtered one
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_q <= 17'h00000;
      state_q <= 1'b0;
    end else if (rawIn == state_q) begin
      count_q <= 17'h00000;
    end else if (count_q >= Cycles - 17'h00001) begin
      count_q <= 17'h00000;
      state_q <= rawIn;
    end else begin
      count_q <= count_q + 17'h00001;
    end
  end

  assign filtOut = state_q;
endmodule // pfs_filter

module pfs_supervisor
  import pfs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // APB slave
  input wire pfs_apb_req_type apbReq,
  output pfs_apb_rsp_type apbRsp,
  // Supply and release pins
  input wire logic main_supply_pin,
  input wire logic power_release_pin,
  // Rail enable pins
  input wire logic rail_enable_pin_a,
  input wire logic rail_enable_pin_b,
  // Analog monitor comparators
  input wire pfs_monitor_type monitor,
  input wire logic outputBelowFault,
  // Power stage controls and interrupt request
  output logic railSwitchEnable,
  output logic dischargeEnable,
  output logic biasEnable,
  output logic interrupt_request_n
);

  typedef struct packed {
    pfs_mode_type mode;
    logic [FlagCount-1:0] flags;
    logic [FlagCount-1:0] mask;
    logic [4:0] control;
    logic railRun;
    logic startCheck;
    logic [16:0] startCnt;
    logic [2:0] otpCnt;
    logic [31:0] rdata;
    logic prevWarn;
    logic prevHot;
    logic prevLimit;
    logic prevGood;
    logic faultSeen;
  } pfs_state_type;

  pfs_state_type s_q;
  pfs_state_type s_d;

  logic enA;
  logic enB;
  logic warnLowF;
  logic warnHighF;
  logic hotF;
  logic limitF;
  logic goodF;
  logic overloadF;
  logic heatWarn;
  logic railRequest;
  logic apbAccess;
  logic apbWrite;
  logic mapped;
  logic [FlagCount-1:0] clearMask;

  pfs_filter #(.Cycles(17'(EnableFilterCycles))) fEnA (
    .ref_clk(ref_clk), .rst(rst), .rawIn(rail_enable_pin_a), .filtOut(enA));
  pfs_filter #(.Cycles(17'(EnableFilterCycles))) fEnB (
    .ref_clk(ref_clk), .rst(rst), .rawIn(rail_enable_pin_b), .filtOut(enB));
  pfs_filter #(.Cycles(17'(SignalFilterCycles))) fWarnL (
    .ref_clk(ref_clk), .rst(rst), .rawIn(monitor.heatWarnLow), .filtOut(warnLowF));
  pfs_filter #(.Cycles(17'(SignalFilterCycles))) fWarnH (
    .ref_clk(ref_clk), .rst(rst), .rawIn(monitor.heatWarnHigh), .filtOut(warnHighF));
  pfs_filter #(.Cycles(17'(SignalFilterCycles))) fHot (
    .ref_clk(ref_clk), .rst(rst), .rawIn(monitor.overheat), .filtOut(hotF));
  pfs_filter #(.Cycles(17'(SignalFilterCycles))) fLim (
    .ref_clk(ref_clk), .rst(rst), .rawIn(monitor.peakLimit), .filtOut(limitF));
  pfs_filter #(.Cycles(17'(SignalFilterCycles))) fGood (
    .ref_clk(ref_clk), .rst(rst), .rawIn(monitor.powerGood), .filtOut(goodF));
  pfs_filter #(.Cycles(17'(OverloadFilterCycles))) fLoad (
    .ref_clk(ref_clk), .rst(rst), .rawIn(monitor.feedbackLow), .filtOut(overloadF));

  assign heatWarn = s_q.control[CtlWarnLevelBit] ? warnHighF : warnLowF;

  // Pin control picks one of the two pins; register bit otherwise
  assign railRequest = s_q.control[CtlPinCtrlBit]
    ? (s_q.control[CtlPinSelectBit] ? enB : enA)
    : s_q.control[CtlRailEnableBit];

  assign apbAccess = apbReq.psel && apbReq.penable;
  assign apbWrite = apbAccess && apbReq.pwrite;
  assign mapped = (apbReq.paddr == FlagsOffset) || (apbReq.paddr == StatusOffset)
    || (apbReq.paddr == ControlOffset) || (apbReq.paddr == MaskOffset);

  always_comb begin
    logic supplyOk;
    logic hotOrPending;
    logic faultNow;
    logic [FlagCount-1:0] setMask;
    supplyOk = main_supply_pin && power_release_pin;
    hotOrPending = 1'b0;
    faultNow = 1'b0;
    setMask = '0;
    s_d = s_q;
    clearMask = '0;
    s_d.prevWarn = heatWarn;
    s_d.prevHot = hotF;
    s_d.prevLimit = limitF;
    s_d.prevGood = goodF;

    if (apbWrite && apbReq.paddr == FlagsOffset) begin
      clearMask = apbReq.pwdata[FlagCount-1:0];
    end
    if (hotF) begin
      clearMask[FlagOverheatBit] = 1'b0;
    end

    if (heatWarn && !s_q.prevWarn) begin
      setMask[FlagHeatWarnBit] = 1'b1;
    end
    if (hotF && !s_q.prevHot) begin
      setMask[FlagOverheatBit] = 1'b1;
    end
    if (limitF && !s_q.prevLimit) begin
      setMask[FlagPeakLimitBit] = 1'b1;
      setMask[FlagRailSummaryBit] = 1'b1;
    end
    if (goodF && !s_q.prevGood && s_q.railRun) begin
      setMask[FlagPowerGoodBit] = 1'b1;
      setMask[FlagRailSummaryBit] = 1'b1;
    end

    // short check 1 ms after enable
    if (s_q.railRun && s_q.startCheck) begin
      if (s_q.startCnt >= 17'(ShortCheckCycles - 1)) begin
        s_d.startCheck = 1'b0;
        faultNow = outputBelowFault;
      end else begin
        s_d.startCnt = s_q.startCnt + 17'h00001;
      end
    end
    if (s_q.railRun && !s_q.startCheck && overloadF) begin
      faultNow = 1'b1;
    end
    if (faultNow) begin
      setMask[FlagRailShortBit] = 1'b1;
      setMask[FlagRailSummaryBit] = 1'b1;
      s_d.railRun = 1'b0;
    end

    // Set beats a simultaneous clear
    s_d.flags = (s_q.flags & ~clearMask) | setMask;

    if (apbWrite && apbReq.paddr == ControlOffset) begin
      s_d.control = apbReq.pwdata[4:0];
    end
    if (apbWrite && apbReq.paddr == MaskOffset) begin
      s_d.mask = apbReq.pwdata[FlagCount-1:0];
    end

    // enable blocked while hot or pending
    hotOrPending = hotF || s_q.flags[FlagOverheatBit];

    unique case (s_q.mode)
      ModeShutdown: begin
        s_d.railRun = 1'b0;
        if (power_release_pin) begin
          s_d.mode = ModeWaitOn;
        end
      end
      ModeWaitOn: begin
        if (supplyOk) begin
          s_d.mode = ModeReadOtp;
          s_d.otpCnt = 3'h0;
        end
      end
      ModeReadOtp: begin
        s_d.control = ControlReset;
        s_d.mask = MaskReset;
        s_d.otpCnt = s_q.otpCnt + 3'h1;
        if (s_q.otpCnt == 3'(OtpLoadCycles - 1)) begin
          s_d.mode = ModeStandby;
          s_d.flags = '0;
          s_d.flags[FlagRegResetBit] = 1'b1;
        end
      end
      ModeStandby: begin
        if (railRequest && !hotOrPending && !s_q.flags[FlagRailShortBit]) begin
          s_d.mode = ModeActive;
          s_d.railRun = 1'b1;
          s_d.startCheck = 1'b1;
          s_d.startCnt = 17'h00000;
        end
      end
      ModeActive: begin
        if (hotF || !railRequest || faultNow || !s_q.railRun) begin
          s_d.railRun = 1'b0;
          s_d.mode = ModeStandby;
        end
      end
      default: s_d.mode = ModeShutdown;
    endcase

    if (!supplyOk && s_q.mode != ModeShutdown && s_q.mode != ModeWaitOn) begin
      s_d.mode = ModeShutdown;
      s_d.railRun = 1'b0;
    end
    if (!power_release_pin) begin
      s_d.mode = ModeShutdown;
      s_d.railRun = 1'b0;
    end

    if (apbAccess && !apbReq.pwrite) begin
      unique case (apbReq.paddr)
        FlagsOffset: s_d.rdata = 32'(s_q.flags);
        StatusOffset: begin
          s_d.rdata = 32'h00000000;
          s_d.rdata[StatHeatWarnBit] = heatWarn;
          s_d.rdata[StatOverheatBit] = hotF;
          s_d.rdata[StatRailRunBit] = s_q.railRun;
          s_d.rdata[StatPeakLimitBit] = limitF;
          s_d.rdata[StatPowerGoodBit] = goodF;
          s_d.rdata[StatModeLsb +: 3] = s_q.mode;
        end
        ControlOffset: s_d.rdata = 32'(s_q.control);
        MaskOffset: s_d.rdata = 32'(s_q.mask);
        default: s_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.mode <= ModeShutdown;
      s_q.control <= ControlReset;
      s_q.mask <= MaskReset;
    end else begin
      s_q <= s_d;
    end
  end

  logic readPhase_q;

  // Read data is registered, so a read takes one wait cycle
  assign apbRsp.pready = apbAccess && (apbReq.pwrite || readPhase_q);
  assign apbRsp.pslverr = apbAccess && !mapped && apbRsp.pready;
  assign apbRsp.prdata = s_q.rdata;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      readPhase_q <= 1'b0;
    end else begin
      readPhase_q <= apbAccess && !apbReq.pwrite && !readPhase_q;
    end
  end

  // stage off on disable, discharge optional
  assign railSwitchEnable = s_q.railRun;
  assign dischargeEnable = !s_q.railRun && s_q.control[CtlDischargeBit]
    && s_q.mode != ModeReadOtp;
  assign biasEnable = s_q.mode != ModeShutdown;
  // low while any unmasked flag pending
  assign interrupt_request_n = !(|(s_q.flags & ~s_q.mask));

endmodule // pfs_supervisor

// *** pfs_pkg.sv ***
package pfs_pkg;

  // Clock and filter timing
  localparam int ClkPeriodNs = 10;
  localparam int EnableFilterNs = 3000;
  localparam int SignalFilterNs = 20000;
  localparam int OverloadFilterUs = 1000;
  localparam int ShortCheckUs = 1000;
  localparam int EnableFilterCycles = (EnableFilterNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int SignalFilterCycles = (SignalFilterNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int OverloadFilterCycles = (OverloadFilterUs * 1000) / ClkPeriodNs;
  localparam int ShortCheckCycles = (ShortCheckUs * 1000) / ClkPeriodNs;
  localparam int OtpLoadCycles = 4;
  localparam int FiltW = 17;

  // APB register offsets
  localparam logic [7:0] FlagsOffset = 8'h00;
  localparam logic [7:0] StatusOffset = 8'h04;
  localparam logic [7:0] ControlOffset = 8'h08;
  localparam logic [7:0] MaskOffset = 8'h0C;

  // Flag bit positions
  localparam int FlagHeatWarnBit = 0;
  localparam int FlagOverheatBit = 1;
  localparam int FlagRailShortBit = 2;
  localparam int FlagRailSummaryBit = 3;
  localparam int FlagRegResetBit = 4;
  localparam int FlagPeakLimitBit = 5;
  localparam int FlagPowerGoodBit = 6;
  localparam int FlagCount = 7;

  // Status bit positions
  localparam int StatHeatWarnBit = 0;
  localparam int StatOverheatBit = 1;
  localparam int StatRailRunBit = 2;
  localparam int StatPeakLimitBit = 3;
  localparam int StatPowerGoodBit = 4;
  localparam int StatModeLsb = 8;

  // Control bit positions
  localparam int CtlRailEnableBit = 0;
  localparam int CtlPinCtrlBit = 1;
  localparam int CtlPinSelectBit = 2;
  localparam int CtlDischargeBit = 3;
  localparam int CtlWarnLevelBit = 4;

  // Reset values
  localparam logic [4:0] ControlReset = 5'h00;
  localparam logic [FlagCount-1:0] MaskReset = 7'h00;

  typedef enum logic [2:0] {
    ModeShutdown, ModeWaitOn, ModeReadOtp, ModeStandby, ModeActive
  } pfs_mode_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pfs_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pfs_apb_rsp_type;

  typedef struct packed {
    logic heatWarnLow;
    logic heatWarnHigh;
    logic overheat;
    logic peakLimit;
    logic powerGood;
    logic feedbackLow;
  } pfs_monitor_type;

endpackage

// *** pfs_supervisor_props.sv ***
`timescale 1ns/100ps
module pfs_supervisor_props
  import pfs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bus
  input wire pfs_apb_req_type apbReq,
  input wire pfs_apb_rsp_type apbRsp,
  // Pins
  input wire logic main_supply_pin,
  input wire logic power_release_pin,
  input wire pfs_monitor_type monitor,
  // Outputs
  input wire logic railSwitchEnable,
  input wire logic dischargeEnable,
  input wire logic biasEnable,
  input wire logic interrupt_request_n
);
  // Margin past the filter so the rail shutdown path has settled
  localparam int HotLimit = SignalFilterCycles + 8;
  logic [15:0] hotCnt_q;
  logic flagWr_q;
  always_ff @(posedge ref_clk) begin
    hotCnt_q <= (rst || !monitor.overheat) ? 16'h0000 : hotCnt_q + {15'h0000, ~&hotCnt_q};
    flagWr_q <= apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready &&
      (apbReq.paddr == FlagsOffset || apbReq.paddr == MaskOffset);
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_RESET_OUT: assert property (
    $fell(rst) |-> !railSwitchEnable && !biasEnable && interrupt_request_n)
    else $error("outputs not at reset values");
  AST_RELEASE_OFF: assert property (
    !power_release_pin [*2] |-> !biasEnable && !railSwitchEnable)
    else $error("release pin low but bias or rail on");
  AST_UVLO_OFF: assert property (
    !main_supply_pin [*2] |-> !railSwitchEnable)
    else $error("supply low but rail on");
  AST_HOT_BLOCK: assert property (
    hotCnt_q > HotLimit |-> !railSwitchEnable)
    else $error("rail on while overheated");
  AST_WR_READY: assert property (
    apbReq.psel && apbReq.penable && apbReq.pwrite |-> apbRsp.pready)
    else $error("write not ready in first access cycle");
  AST_RD_WAIT: assert property (
    apbReq.psel && !apbReq.pwrite && $rose(apbReq.penable) |-> !apbRsp.pready ##1 apbRsp.pready)
    else $error("read wait state wrong");
  AST_UNMAPPED: assert property (
    apbReq.psel && apbReq.penable && apbRsp.pready |->
      apbRsp.pslverr == !(apbReq.paddr == FlagsOffset || apbReq.paddr == StatusOffset
        || apbReq.paddr == ControlOffset || apbReq.paddr == MaskOffset))
    else $error("slave error does not match address");
  AST_INT_RELEASE: assert property (
    $rose(interrupt_request_n) |-> flagWr_q)
    else $error("interrupt released without flag write");
  AST_ON_NEEDS_BIAS: assert property (
    railSwitchEnable |-> biasEnable && !dischargeEnable)
    else $error("rail on without bias or with discharge");
endmodule // pfs_supervisor_props

bind pfs_supervisor pfs_supervisor_props u_props (.ref_clk, .rst, .apbReq, .apbRsp,
  .main_supply_pin, .power_release_pin, .monitor, .railSwitchEnable, .dischargeEnable,
  .biasEnable, .interrupt_request_n);

// *** pfs_host_model.sv ***
`timescale 1ns/100ps
module pfs_host_model
  import pfs_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Bus
  output pfs_apb_req_type apbReq,
  input wire pfs_apb_rsp_type apbRsp
);
  initial apbReq = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    apbReq.psel <= 1'b1;
    apbReq.pwrite <= w;
    apbReq.paddr <= a;
    apbReq.pwdata <= d;
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    do @(posedge ref_clk); while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    // Released data flips so stale values cannot pass
    apbReq.pwdata <= ~d;
  endtask
endmodule // pfs_host_model

// *** protection_fault_supervisor_tb_top.sv ***
`timescale 1ns/100ps
module protection_fault_supervisor_tb_top
  import pfs_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic main_supply_pin = 1'b1;
  logic power_release_pin = 1'b0;
  logic pinA = 1'b0;
  pfs_monitor_type monitor = '0;
  pfs_apb_req_type apbReq;
  pfs_apb_rsp_type apbRsp;
  logic railSwitchEnable, dischargeEnable, biasEnable, interrupt_request_n;
  logic [31:0] rdData;
  logic rdErr;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [7:0] rowAddr [5] = '{FlagsOffset, ControlOffset, MaskOffset, StatusOffset, 8'h10};
  logic [31:0] rowData [5] = '{32'h10, 32'h0, 32'h0, 32'h300, 32'h0};
  logic rowErr [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

  pfs_supervisor u_dut (.ref_clk, .rst, .apbReq, .apbRsp, .main_supply_pin,
    .power_release_pin, .rail_enable_pin_a(pinA), .rail_enable_pin_b(1'b0), .monitor,
    .outputBelowFault(1'b0), .railSwitchEnable, .dischargeEnable, .biasEnable,
    .interrupt_request_n);
  pfs_host_model u_host (.ref_clk, .apbReq, .apbRsp);

  initial forever #5 ref_clk = ~ref_clk;

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee = 1'b0);
    u_host.xfer(1'b0, a, 32'h0, rdData, rdErr);
    chk(e, rdData);
    chk(ee, rdErr);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rdData, rdErr);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  initial begin
    wt(5);
    rst <= 1'b0;
    wt(1);
    chk(1'b0, biasEnable); chk(1'b1, interrupt_request_n);
    power_release_pin <= 1'b1;
    wt(12);
    for (int i = 0; i < 5; i++) rd(rowAddr[i], rowData[i], rowErr[i]);
    chk(1'b0, interrupt_request_n);
    wr(FlagsOffset, 32'h0); rd(FlagsOffset, 32'h10);
    wr(FlagsOffset, 32'h10); rd(FlagsOffset, 32'h0); chk(1'b1, interrupt_request_n);
    $display("test reset done");
    wr(ControlOffset, 32'h10);
    monitor.heatWarnLow <= 1'b1;
    wt(2100);
    rd(FlagsOffset, 32'h0);
    wr(ControlOffset, 32'h0);
    wt(2100);
    rd(FlagsOffset, 32'h1); rd(StatusOffset, 32'h301);
    monitor.heatWarnLow <= 1'b0;
    wt(2100);
    wr(FlagsOffset, 32'h1); rd(FlagsOffset, 32'h0); chk(1'b1, interrupt_request_n);
    $display("test warning done");
    wr(ControlOffset, 32'h9);
    wt(5);
    chk(1'b1, railSwitchEnable); rd(StatusOffset, 32'h404);
    monitor.overheat <= 1'b1;
    wt(2100);
    chk(1'b0, railSwitchEnable); chk(1'b1, dischargeEnable);
    rd(FlagsOffset, 32'h2); rd(StatusOffset, 32'h302);
    wr(FlagsOffset, 32'h2); rd(FlagsOffset, 32'h2); chk(1'b0, railSwitchEnable);
    monitor.overheat <= 1'b0;
    wt(2100);
    wr(FlagsOffset, 32'h2); rd(FlagsOffset, 32'h0);
    $display("test overheat done");
    main_supply_pin <= 1'b0;
    wt(3);
    chk(1'b0, railSwitchEnable);
    chk(1'b1, dischargeEnable);
    rd(StatusOffset, 32'h100);
    main_supply_pin <= 1'b1;
    wt(12);
    rd(FlagsOffset, 32'h10); rd(ControlOffset, 32'h0);
    $display("test supply done");
    wr(FlagsOffset, 32'h10);
    wr(ControlOffset, 32'h2);
    pinA <= 1'b1;
    wt(250);
    chk(1'b0, railSwitchEnable); wt(100); chk(1'b1, railSwitchEnable);
    pinA <= 1'b0;
    wt(250);
    chk(1'b1, railSwitchEnable); wt(100); chk(1'b0, railSwitchEnable);
    $display("test pin done");
    give_verdict();
  end
endmodule // protection_fault_supervisor_tb_top
